// File: hdl/bca_accum.sv
`timescale 1ns/1ps
// Behaviour
// - Conversions run only while measurement enabled.
// - Current equals raw result plus offset.
// - Offset top four bits carry sign.
// - Current is two's complement, positive charging.
// - One sample per period updates accumulators.
// - Net accumulator counts up charging, down discharging.
// - Net count unit fixed by scaling.
// - Net accumulator frozen while measurement disabled.
// - Charge total positive only, discharge negative only.
// - Samples at or below threshold discarded.
// - Threshold code in top two bits.
// - Lifetime totals sixteen bits, fixed unit.
// - Mode bits select which accumulators run.
// - Page is general storage unless totals enabled.
// - Shadow copy only when shadow enabled.
// - Net reaching zero leaves totals unchanged.
module bca_accum
  import bca_pkg::*;
#(
  parameter int SAMPLE_PERIOD_CYC = bca_pkg::SAMPLE_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic meas_enable_i,
  input wire logic lifetime_accum_enable_i,
  input wire logic shadow_enable_i,
  input wire logic [bca_pkg::CUR_W-1:0] raw_result_i,
  input wire logic [bca_pkg::CUR_W-1:0] wr_data_i,
  input wire logic wr_offset_i,
  input wire logic wr_threshold_i,
  input wire logic wr_net_i,
  input wire logic wr_charge_i,
  input wire logic wr_discharge_i,
  output logic conv_start_o,
  output logic [bca_pkg::CUR_W-1:0] current_o,
  output logic [bca_pkg::CUR_W-1:0] current_offset_correction_o,
  output logic [7:0] small_signal_threshold_o,
  output logic [bca_pkg::NET_W-1:0] net_charge_accumulator_o,
  output logic [bca_pkg::TOT_W-1:0] charge_total_accumulator_o,
  output logic [bca_pkg::TOT_W-1:0] discharge_total_accumulator_o,
  output logic page_general_o,
  output logic nv_copy_o,
  output logic [bca_pkg::TOT_W-1:0] nv_charge_o,
  output logic [bca_pkg::TOT_W-1:0] nv_discharge_o
);
  import bca_pkg::*;

  localparam int NF_W = NET_W + NET_FRAC;
  localparam int TF_W = TOT_W + TOT_FRAC;
  localparam logic [NF_W-1:0] NET_MAX = '1;

  function automatic logic [CUR_W-1:0] thr_counts(input logic [1:0] sel);
    unique case (sel)
      THR_NONE: thr_counts = '0;
      THR_2: thr_counts = THR_CNT_2;
      THR_4: thr_counts = THR_CNT_4;
      default: thr_counts = THR_CNT_8;
    endcase
  endfunction : thr_counts

  function automatic logic [CUR_W-1:0] magnitude(input logic [CUR_W-1:0] v);
    magnitude = v[CUR_W-1] ? CUR_W'(-v) : v;
  endfunction : magnitude

  logic tick;
  logic cur_vld;
  logic [NF_W-1:0] net_full;
  logic [TF_W-1:0] chg_full;
  logic [TF_W-1:0] dis_full;
  logic [CUR_W-1:0] ofs_scaled;
  logic [CUR_W-1:0] mag;
  logic accept;
  logic tot_run;
  logic [NF_W+1:0] net_sum;
  logic [NF_W-1:0] next_net;

  bca_timebase #(
    .PERIOD_CYC(SAMPLE_PERIOD_CYC)
  ) u_timebase (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .run_i(meas_enable_i),
    .tick_o(tick)
  );

  // The offset keeps three fraction bits below the current's unit.
  assign ofs_scaled = CUR_W'($signed(current_offset_correction_o) >>> OFS_SHIFT);
  assign mag = magnitude(current_o);
  assign accept = cur_vld && meas_enable_i
               && (mag > thr_counts(small_signal_threshold_o[THR_SEL_HI:THR_SEL_LO]));
  assign tot_run = meas_enable_i && lifetime_accum_enable_i;
  assign net_sum = {2'b00, net_full}
                 + {{(NF_W + 2 - CUR_W){current_o[CUR_W-1]}}, current_o};

  // Clamping instead of wrapping keeps a full or empty gauge from flipping.
  always_comb begin
    if (net_sum[NF_W+1]) begin
      next_net = '0;
    end else if (net_sum[NF_W]) begin
      next_net = NET_MAX;
    end else begin
      next_net = net_sum[NF_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conv_start_o <= 1'b0;
      cur_vld <= 1'b0;
      current_o <= '0;
    end else begin
      conv_start_o <= tick;
      cur_vld <= tick;
      if (tick) begin
        current_o <= raw_result_i + ofs_scaled;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      current_offset_correction_o <= OFS_RESET;
      small_signal_threshold_o <= THR_RESET;
    end else begin
      if (wr_offset_i) begin
        current_offset_correction_o <= {{(OFS_SIGN_TOP - OFS_SIGN_BIT){wr_data_i[OFS_SIGN_BIT]}},
                                        wr_data_i[OFS_SIGN_BIT:0]};
      end
      if (wr_threshold_i) begin
        small_signal_threshold_o <= {wr_data_i[THR_SEL_HI:THR_SEL_LO], 6'h00};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      net_full <= '0;
    end else if (wr_net_i) begin
      net_full <= {wr_data_i[NET_W-1:0], {NET_FRAC{1'b0}}};
    end else if (accept) begin
      net_full <= next_net;
    end
  end
  assign net_charge_accumulator_o = net_full[NF_W-1:NET_FRAC];

  // Totals ignore the net count, so an empty gauge never touches them.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chg_full <= '0;
      dis_full <= '0;
    end else begin
      if (wr_charge_i) begin
        chg_full <= {wr_data_i[TOT_W-1:0], {TOT_FRAC{1'b0}}};
      end else if (accept && tot_run && !current_o[CUR_W-1]) begin
        chg_full <= chg_full + TF_W'(mag);
      end
      if (wr_discharge_i) begin
        dis_full <= {wr_data_i[TOT_W-1:0], {TOT_FRAC{1'b0}}};
      end else if (accept && tot_run && current_o[CUR_W-1]) begin
        dis_full <= dis_full + TF_W'(mag);
      end
    end
  end
  assign charge_total_accumulator_o = chg_full[TF_W-1:TOT_FRAC];
  assign discharge_total_accumulator_o = dis_full[TF_W-1:TOT_FRAC];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      page_general_o <= 1'b1;
      nv_copy_o <= 1'b0;
      nv_charge_o <= '0;
      nv_discharge_o <= '0;
    end else begin
      page_general_o <= !tot_run;
      nv_copy_o <= accept && tot_run && shadow_enable_i;
      if (accept && tot_run && shadow_enable_i) begin
        nv_charge_o <= charge_total_accumulator_o;
        nv_discharge_o <= discharge_total_accumulator_o;
      end
    end
  end

  a_no_conv_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !meas_enable_i |=> ##1 !conv_start_o)
    else $error("conversion started while measurement disabled");
  a_current_sum: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tick |=> current_o == CUR_W'($past(raw_result_i) + $past(ofs_scaled)))
    else $error("current is not raw plus offset");
  a_offset_sign: assert property (@(posedge clk_i) disable iff (!rstn_i)
    current_offset_correction_o[OFS_SIGN_TOP:OFS_SIGN_BIT] == '0
    || current_offset_correction_o[OFS_SIGN_TOP:OFS_SIGN_BIT] == '1)
    else $error("offset sign bits disagree");
  a_net_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !meas_enable_i && !wr_net_i |=> $stable(net_charge_accumulator_o))
    else $error("net accumulator moved while disabled");
  a_net_up: assert property (@(posedge clk_i) disable iff (!rstn_i)
    accept && !current_o[CUR_W-1] && !wr_net_i |=>
    net_charge_accumulator_o >= $past(net_charge_accumulator_o))
    else $error("net accumulator fell on charge");
  a_charge_sign: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cur_vld && current_o[CUR_W-1] && !wr_charge_i |=> $stable(chg_full))
    else $error("charge total moved on discharge sample");
  a_thresh_drop: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cur_vld && mag <= thr_counts(small_signal_threshold_o[THR_SEL_HI:THR_SEL_LO])
    && !wr_net_i |=> $stable(net_full))
    else $error("small sample accumulated");
  a_totals_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !tot_run && !wr_charge_i && !wr_discharge_i |=> $stable(chg_full) && $stable(dis_full))
    else $error("totals moved while disabled");
  a_page_mode: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 page_general_o == !$past(tot_run))
    else $error("page mode wrong");
  a_shadow_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !shadow_enable_i |=> !nv_copy_o)
    else $error("shadow copy while shadow disabled");

  c_sample: cover property (@(posedge clk_i) disable iff (!rstn_i) accept);
  c_discharge: cover property (@(posedge clk_i) disable iff (!rstn_i)
    accept && tot_run && current_o[CUR_W-1]);
  c_shadow: cover property (@(posedge clk_i) disable iff (!rstn_i) nv_copy_o);
endmodule : bca_accum

// File: hdl/bca_pkg.sv
package bca_pkg;
  localparam int CUR_W = 16;
  localparam int NET_W = 8;
  localparam int TOT_W = 16;
  // One current count held for one sample period is 2**-18 of a net count
  // and 2**-23 of a lifetime count, so these remainders carry sub-count charge.
  localparam int NET_FRAC = 18;
  localparam int TOT_FRAC = 23;
  localparam int OFS_SHIFT = 3;
  localparam int OFS_SIGN_BIT = 12;
  localparam int OFS_SIGN_TOP = 15;
  localparam int THR_SEL_HI = 7;
  localparam int THR_SEL_LO = 6;
  localparam logic [1:0] THR_NONE = 2'h0;
  localparam logic [1:0] THR_2 = 2'h1;
  localparam logic [1:0] THR_4 = 2'h2;
  localparam logic [CUR_W-1:0] THR_CNT_2 = 16'h0002;
  localparam logic [CUR_W-1:0] THR_CNT_4 = 16'h0004;
  localparam logic [CUR_W-1:0] THR_CNT_8 = 16'h0008;
  localparam logic [7:0] THR_RESET = 8'h00;
  localparam logic [CUR_W-1:0] OFS_RESET = 16'h0000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SAMPLE_PERIOD_NS = 27460000;
  localparam int SAMPLE_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
endpackage : bca_pkg

// File: hdl/bca_timebase.sv
`timescale 1ns/1ps
module bca_timebase #(
  parameter int PERIOD_CYC = 274600
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic run_i,
  output logic tick_o
);
  logic [31:0] cnt;

  // A period below two cycles would leave no idle cycle between ticks.
  if (PERIOD_CYC < 2) begin : g_bad_period
    $error("bca_timebase: period too short");
  end

  // Stopping clears the count so a restart waits one full period.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 32'h0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt == 32'(PERIOD_CYC - 1)) begin
      cnt <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule : bca_timebase

// File: testbench/battery_current_accumulators_tb.sv
`timescale 1ns/1ps
module battery_current_accumulators_tb;
  import bca_pkg::*;
  localparam int PER = 20;
  logic clk_i, rstn_i, meas, life, shad, conv, nvc, pg;
  logic [4:0] wr;
  logic [15:0] wd, raw, cur, ofs, chg, dis, nvq, nvd;
  logic [7:0] thr, net;
  int bad_count = 0;
  int compares = 0;
  int n_conv = 0;
  int n_nv = 0;
  int base_c, base_n;

  bca_host host (.clk_i(clk_i), .meas_enable_o(meas), .lifetime_accum_enable_o(life),
    .shadow_enable_o(shad), .wr_data_o(wd), .wr_o(wr));

  bca_accum #(.SAMPLE_PERIOD_CYC(PER)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
    .meas_enable_i(meas), .lifetime_accum_enable_i(life), .shadow_enable_i(shad),
    .raw_result_i(raw), .wr_data_i(wd), .wr_offset_i(wr[0]), .wr_threshold_i(wr[1]),
    .wr_net_i(wr[2]), .wr_charge_i(wr[3]), .wr_discharge_i(wr[4]), .conv_start_o(conv),
    .current_o(cur), .current_offset_correction_o(ofs), .small_signal_threshold_o(thr),
    .net_charge_accumulator_o(net), .charge_total_accumulator_o(chg),
    .discharge_total_accumulator_o(dis), .page_general_o(pg), .nv_copy_o(nvc),
    .nv_charge_o(nvq), .nv_discharge_o(nvd));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (conv === 1'b1) n_conv++;
    if (nvc === 1'b1) n_nv++;
  end

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // Each sample ends two edges after its pulse, when the accumulators have settled.
  task automatic samples(input int n);
    int k;
    repeat (n) begin
      k = 0;
      while (conv !== 1'b1 && k < 100) begin
        @(posedge clk_i);
        k++;
      end
      if (k == 100) bad_count++;
      repeat (2) @(posedge clk_i);
    end
  endtask : samples

  task automatic give_verdict();
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    give_verdict();
  end

  initial begin
    rstn_i = 1'b0;
    raw = 16'h0000;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    check("threshold", 16'h0000, thr);
    check("page", 16'h0001, pg);
    host.write_reg(0, 16'h2812);
    check("offset", 16'h0812, ofs);
    host.write_reg(0, 16'h1812);
    check("offset", 16'hf812, ofs);
    host.write_reg(1, 16'h00ff);
    check("threshold", 16'h00c0, thr);
    host.write_reg(1, 16'h0000);
    host.write_reg(0, 16'h0000);
    raw <= 16'h0005;
    host.mode(1'b1, 1'b0, 1'b0);
    samples(1);
    check("current", 16'h0005, cur);
    host.calibrate(cur);
    check("offset", 16'hffd8, ofs);
    samples(1);
    check("current", 16'h0000, cur);
    host.write_reg(0, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      host.write_reg(1, 16'(c << 6));
      host.write_reg(2, 16'h0040);
      raw <= -16'((c == 0) ? 0 : (1 << c));
      samples(1);
      check("net", 16'h0040, net);
      raw <= -16'(((c == 0) ? 0 : (1 << c)) + 1);
      samples(1);
      check("net", 16'h003f, net);
    end
    host.write_reg(1, 16'h0000);
    host.write_reg(2, 16'h0080);
    host.write_reg(3, 16'h00ff);
    host.write_reg(4, 16'h1234);
    raw <= 16'h8000;
    base_c = n_conv;
    base_n = n_nv;
    host.mode(1'b1, 1'b1, 1'b1);
    samples(255);
    check("discharge", 16'h1234, dis);
    check("copies", 16'd255, 16'(n_nv - base_n));
    check("nv discharge", 16'h1234, nvd);
    check("nv charge", 16'h00ff, nvq);
    host.mode(1'b1, 1'b0, 1'b1);
    samples(1);
    check("discharge", 16'h1234, dis);
    check("page", 16'h0001, pg);
    host.mode(1'b1, 1'b1, 1'b0);
    samples(1);
    check("discharge", 16'h1235, dis);
    check("charge", 16'h00ff, chg);
    check("copies", 16'd255, 16'(n_nv - base_n));
    check("page", 16'h0000, pg);
    check("net", 16'h005f, net);
    check("samples", 16'd257, 16'(n_conv - base_c));
    host.mode(1'b1, 1'b1, 1'b0);
    host.write_reg(2, 16'h0001);
    samples(16);
    check("net", 16'h0000, net);
    check("discharge", 16'h1235, dis);
    host.write_reg(2, 16'h00fe);
    raw <= 16'h7fff;
    samples(9);
    check("net", 16'h00ff, net);
    samples(9);
    check("net", 16'h00ff, net);
    host.write_reg(2, 16'h0010);
    raw <= 16'h8000;
    host.mode(1'b0, 1'b0, 1'b0);
    base_c = n_conv;
    repeat (3 * PER) @(posedge clk_i);
    check("samples", 16'h0000, 16'(n_conv - base_c));
    check("net", 16'h0010, net);
    give_verdict();
  end
endmodule : battery_current_accumulators_tb

// File: testbench/bca_host.sv
`timescale 1ns/1ps
module bca_host (
  input wire logic clk_i,
  output logic meas_enable_o,
  output logic lifetime_accum_enable_o,
  output logic shadow_enable_o,
  output logic [15:0] wr_data_o,
  output logic [4:0] wr_o
);
  // Strobe order in wr_o: offset, threshold, net, charge total, discharge total.
  initial begin
    meas_enable_o = 1'b0;
    lifetime_accum_enable_o = 1'b0;
    shadow_enable_o = 1'b0;
    wr_data_o = 16'h0000;
    wr_o = 5'h00;
  end

  task automatic mode(input logic m, input logic l, input logic s);
    @(posedge clk_i);
    meas_enable_o <= m;
    lifetime_accum_enable_o <= l;
    shadow_enable_o <= s;
  endtask : mode

  // Parking measurement also restarts the sample timer, so the next sample is a full period away.
  task automatic write_reg(input int sel, input logic [15:0] d);
    logic m;
    logic l;
    // The mode is captured after an edge, so a change still pending from the call before is seen.
    @(posedge clk_i);
    m = meas_enable_o;
    l = lifetime_accum_enable_o;
    meas_enable_o <= 1'b0;
    lifetime_accum_enable_o <= 1'b0;
    @(posedge clk_i);
    wr_data_o <= d;
    wr_o <= 5'h01 << sel;
    @(posedge clk_i);
    wr_o <= 5'h00;
    mode(m, l, shadow_enable_o);
  endtask : write_reg

  // The offset holds three fraction bits, so the negated reading is shifted into place.
  task automatic calibrate(input logic [15:0] reading);
    write_reg(0, (16'h0000 - reading) << 3);
  endtask : calibrate
endmodule : bca_host
